// >>> mwdt_pkg.sv
// Constants, field positions and types of the memory wait and DRAM timing block.
// Assumes one system clock and an APB master with 32-bit data.
package mwdt_pkg;

  // Register byte addresses on the bus.
  localparam logic [31:0] WAIT_CTRL_ADDR = 32'hffffffe8;
  localparam logic [31:0] MEM_CTRL_ADDR = 32'hffffffec;

  // Reset values and writable bit masks.
  localparam logic [15:0] WAIT_CTRL_RST = 16'haaff;
  localparam logic [15:0] MEM_CTRL_RST = 16'h0000;
  localparam logic [15:0] MEM_CTRL_WMASK = 16'hfefc;

  // Wait register field positions.
  localparam int IDLE_LSB = 8;
  localparam int WAIT_LSB = 0;

  // Memory control register field positions.
  localparam int PRECHARGE_BIT = 15;
  localparam int ROW_COL_BIT = 14;
  localparam int WR_PRECHARGE_BIT = 13;
  localparam int RAS_WIDTH_MSB = 12;
  localparam int RAS_WIDTH_LSB = 11;
  localparam int BURST_BIT = 10;
  localparam int BANK_OPEN_BIT = 9;
  localparam int COL_SEL2_BIT = 7;
  localparam int WORD_SIZE_BIT = 6;
  localparam int COL_SEL1_BIT = 5;
  localparam int COL_SEL0_BIT = 4;
  localparam int REFRESH_BIT = 3;
  localparam int REFRESH_MODE_BIT = 2;

  // Wait field codes.
  localparam logic [1:0] WAIT_LONG = 2'h3;
  localparam logic [1:0] IDLE_RESERVED = 2'h3;

  // Timing counts in clock cycles, and the base column address width in bits.
  localparam logic [2:0] LONG_WAIT_BASE = 3'h3;
  localparam logic [1:0] ONE_CYCLE = 2'h1;
  localparam logic [1:0] TWO_CYCLES = 2'h2;
  localparam logic [2:0] RAS_WIDTH_BASE = 3'h2;
  localparam logic [2:0] PSRAM_SHORT = 3'h2;
  localparam logic [2:0] PSRAM_LONG = 3'h4;
  localparam logic [3:0] COL_BITS_BASE = 4'h8;

  // Area type codes from the first bus control register.
  localparam logic [2:0] TYPE_ORDINARY = 3'h0;
  localparam logic [2:0] TYPE_A3_SDRAM = 3'h1;
  localparam logic [2:0] TYPE_A3_DRAM = 3'h2;
  localparam logic [2:0] TYPE_A3_PSRAM = 3'h3;
  localparam logic [2:0] TYPE_A2_SDRAM = 3'h4;
  localparam logic [2:0] TYPE_BOTH_SDRAM = 3'h5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_EXTW = 2'b10,
    ST_GAP = 2'b11
  } mwdt_state_t;

endpackage : mwdt_pkg

// >>> mwdt_ctrl.sv
// Wait-state and DRAM timing configuration block with a basic-cycle sequencer.
// Assumes an APB master on mclk_in and area types and long waits from bus control.
//
// Function
// R1: per-area two-bit idle code gives zero, one or two idle cycles; reset two.
// R2: basic wait code 11 uses the area's long-wait count from bus control.
// R3: with wait code 11 the external wait input extends the access.
// R4: DRAM area 3 wait code selects one, two or three CAS cycles.
// R5: SDRAM in area 2 or 3: wait code gives CAS latency one or two.
// R6: pseudo-SRAM area 3 wait code gives cycle length two or four.
// R7: precharge, row-to-column and write-precharge bits select one or two cycles.
// R8: refresh row strobe width code gives two, three or four cycles.
// R9: burst enable clear at reset; set selects page mode for DRAM.
// R10: burst enable with pseudo-SRAM selects static column mode.
// R11: synchronous DRAM always uses burst transfers.
// R12: bank-open clear gives SDRAM auto-precharge, activate on each access.
// R13: bank-open set leaves the area 3 SDRAM bank open.
// R14: area 2 SDRAM always uses auto-precharge.
// R15: refresh control clear at reset; set enables refresh.
// R16: refresh mode bit selects normal or self refresh.
// R17: column select field gives 8 to 11 column address bits.
// R18: long-wait codes 00 to 11 give three to six waits.
`timescale 1ns/100ps

module mwdt_ctrl (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [2:0] area_type_in,
  input wire logic [1:0] long_wait_a0_in,
  input wire logic [1:0] long_wait_a1_in,
  input wire logic [1:0] long_wait_a23_in,
  input wire logic access_req_in,
  input wire logic [1:0] access_area_in,
  input wire logic ext_wait_in,
  output logic access_busy_out,
  output logic access_done_out,
  output logic [1:0] cas_assert_cycles_out,
  output logic [1:0] a2_cas_latency_out,
  output logic [1:0] a3_cas_latency_out,
  output logic [2:0] psram_cycles_out,
  output logic [1:0] precharge_cycles_out,
  output logic [1:0] row_col_cycles_out,
  output logic [1:0] wr_precharge_cycles_out,
  output logic [2:0] refresh_ras_cycles_out,
  output logic page_mode_out,
  output logic static_column_out,
  output logic sdram_burst_out,
  output logic a2_auto_precharge_out,
  output logic a3_auto_precharge_out,
  output logic refresh_enable_out,
  output logic self_refresh_out,
  output logic word_size_long_out,
  output logic [3:0] column_bits_out
);

  logic [15:0] wait_ctrl_ff;
  logic [15:0] mem_ctrl_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  mwdt_pkg::mwdt_state_t state_ff;
  mwdt_pkg::mwdt_state_t nxt_state;
  logic [1:0] area_ff;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic ext_en_ff;
  logic busy_ff;
  logic done_ff;

  wire logic access_phase = psel_in & penable_in;
  wire logic hit_wait = (paddr_in == mwdt_pkg::WAIT_CTRL_ADDR);
  wire logic hit_mem = (paddr_in == mwdt_pkg::MEM_CTRL_ADDR);
  wire logic wr_commit = access_phase & pready_ff & pwrite_in;

  // Ordinary areas use the basic-cycle wait meaning of their wait field.
  function automatic logic area_is_ordinary(input logic [1:0] area, input logic [2:0] atype);
    logic result;
    result = 1'b1;
    if (area == 2'h2) begin
      result = !atype[2];
    end else if (area == 2'h3) begin
      result = (atype == mwdt_pkg::TYPE_ORDINARY) || (atype == mwdt_pkg::TYPE_A2_SDRAM);
    end
    return result;
  endfunction : area_is_ordinary

  // Long-wait count of an area: three plus the two-bit code.
  function automatic logic [2:0] long_waits(input logic [1:0] area, input logic [1:0] lw0,
                                            input logic [1:0] lw1, input logic [1:0] lw23);
    logic [1:0] code;
    code = (area == 2'h0) ? lw0 : (area == 2'h1) ? lw1 : lw23;
    return mwdt_pkg::LONG_WAIT_BASE + {1'b0, code}; // see R18
  endfunction : long_waits

  wire logic [1:0] req_wait_code = wait_ctrl_ff[mwdt_pkg::WAIT_LSB + 2 * access_area_in +: 2];
  wire logic [1:0] cur_idle_code = wait_ctrl_ff[mwdt_pkg::IDLE_LSB + 2 * area_ff +: 2];
  wire logic req_ordinary = area_is_ordinary(access_area_in, area_type_in);

  // Each bus access is answered one cycle after its access phase starts, so pready is a flop.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= access_phase & ~pready_ff;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else if (access_phase & ~pready_ff) begin
      pslverr_ff <= ~(hit_wait | hit_mem);
      prdata_ff <= 32'h0;
      if (!pwrite_in && hit_wait) begin
        prdata_ff <= {16'h0, wait_ctrl_ff};
      end else if (!pwrite_in && hit_mem) begin
        prdata_ff <= {16'h0, mem_ctrl_ff};
      end
    end else begin
      pslverr_ff <= 1'b0;
    end
  end

  // Reserved codes are stored as written; the decode uses documented maxima, except SDRAM code 10 (latency one) and column codes (old width kept).
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wait_ctrl_ff <= mwdt_pkg::WAIT_CTRL_RST; // see R1
    end else if (wr_commit && hit_wait) begin
      wait_ctrl_ff <= pwdata_in[15:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mem_ctrl_ff <= mwdt_pkg::MEM_CTRL_RST; // see R9, R15
    end else if (wr_commit && hit_mem) begin
      mem_ctrl_ff <= pwdata_in[15:0] & mwdt_pkg::MEM_CTRL_WMASK;
    end
  end

  // Basic-cycle sequencer: wait states, external wait, then idle gap.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      mwdt_pkg::ST_IDLE: begin
        if (access_req_in) begin
          nxt_state = mwdt_pkg::ST_WAIT;
          nxt_cnt = 3'h0;
          if (req_ordinary) begin
            if (req_wait_code == mwdt_pkg::WAIT_LONG) begin
              nxt_cnt = long_waits(access_area_in, long_wait_a0_in, long_wait_a1_in,
                                   long_wait_a23_in); // see R2
            end else begin
              nxt_cnt = {1'b0, req_wait_code};
            end
          end
        end
      end
      mwdt_pkg::ST_WAIT: begin
        if (cnt_ff != 3'h0) begin
          nxt_cnt = cnt_ff - 3'h1;
        end else if (ext_en_ff && ext_wait_in) begin
          nxt_state = mwdt_pkg::ST_EXTW; // see R3
        end else begin
          nxt_state = (cur_idle_code == 2'h0) ? mwdt_pkg::ST_IDLE : mwdt_pkg::ST_GAP;
          nxt_cnt = (cur_idle_code == mwdt_pkg::IDLE_RESERVED) ? 3'h1 :
                    {1'b0, cur_idle_code} - 3'h1; // see R1
        end
      end
      mwdt_pkg::ST_EXTW: begin
        if (!ext_wait_in) begin
          nxt_state = (cur_idle_code == 2'h0) ? mwdt_pkg::ST_IDLE : mwdt_pkg::ST_GAP;
          nxt_cnt = (cur_idle_code == mwdt_pkg::IDLE_RESERVED) ? 3'h1 :
                    {1'b0, cur_idle_code} - 3'h1; // see R1, R3
        end
      end
      mwdt_pkg::ST_GAP: begin
        if (cnt_ff == 3'h0) begin
          nxt_state = mwdt_pkg::ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_ff <= mwdt_pkg::ST_IDLE;
      cnt_ff <= 3'h0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      busy_ff <= (nxt_state != mwdt_pkg::ST_IDLE);
    end
  end

  // The area and its external wait enable are latched so a later register write cannot
  // change the external wait of the cycle that is already running; its idle gap follows the live idle field.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      area_ff <= 2'h0;
      ext_en_ff <= 1'b0;
    end else if (state_ff == mwdt_pkg::ST_IDLE && access_req_in) begin
      area_ff <= access_area_in;
      ext_en_ff <= req_ordinary && (req_wait_code == mwdt_pkg::WAIT_LONG); // see R3
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == mwdt_pkg::ST_WAIT || state_ff == mwdt_pkg::ST_EXTW) &&
                 (nxt_state == mwdt_pkg::ST_GAP || nxt_state == mwdt_pkg::ST_IDLE);
    end
  end

  // Memory-type timing decode, registered so every output comes from a flop.
  wire logic [1:0] a3_code = wait_ctrl_ff[mwdt_pkg::WAIT_LSB + 6 +: 2];
  wire logic [1:0] a2_code = wait_ctrl_ff[mwdt_pkg::WAIT_LSB + 4 +: 2];
  wire logic [1:0] ras_code = mem_ctrl_ff[mwdt_pkg::RAS_WIDTH_MSB:mwdt_pkg::RAS_WIDTH_LSB];
  wire logic [2:0] col_code = {mem_ctrl_ff[mwdt_pkg::COL_SEL2_BIT],
                               mem_ctrl_ff[mwdt_pkg::COL_SEL1_BIT],
                               mem_ctrl_ff[mwdt_pkg::COL_SEL0_BIT]};
  wire logic a3_sdram = (area_type_in == mwdt_pkg::TYPE_A3_SDRAM) ||
                        (area_type_in == mwdt_pkg::TYPE_BOTH_SDRAM);
  wire logic a2_sdram = (area_type_in == mwdt_pkg::TYPE_A2_SDRAM) ||
                        (area_type_in == mwdt_pkg::TYPE_BOTH_SDRAM);
  wire logic a3_dram = (area_type_in == mwdt_pkg::TYPE_A3_DRAM);
  wire logic a3_psram = (area_type_in == mwdt_pkg::TYPE_A3_PSRAM);
  wire logic burst_en = mem_ctrl_ff[mwdt_pkg::BURST_BIT];
  wire logic bank_open = mem_ctrl_ff[mwdt_pkg::BANK_OPEN_BIT];

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      cas_assert_cycles_out <= 2'h0;
      a2_cas_latency_out <= 2'h0;
      a3_cas_latency_out <= 2'h0;
      psram_cycles_out <= 3'h0;
    end else begin
      cas_assert_cycles_out <= a3_dram ? ((a3_code == 2'h3) ? 2'h3 : a3_code + 2'h1) :
                               2'h0; // see R4
      a2_cas_latency_out <= a2_sdram ? (a2_code[0] ? mwdt_pkg::TWO_CYCLES :
                                        mwdt_pkg::ONE_CYCLE) : 2'h0; // see R5
      a3_cas_latency_out <= a3_sdram ? (a3_code[0] ? mwdt_pkg::TWO_CYCLES :
                                        mwdt_pkg::ONE_CYCLE) : 2'h0; // see R5
      psram_cycles_out <= a3_psram ? ((a3_code == 2'h0) ? mwdt_pkg::PSRAM_SHORT :
                                      mwdt_pkg::PSRAM_LONG) : 3'h0; // see R6
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      precharge_cycles_out <= mwdt_pkg::ONE_CYCLE;
      row_col_cycles_out <= mwdt_pkg::ONE_CYCLE;
      wr_precharge_cycles_out <= mwdt_pkg::ONE_CYCLE;
      refresh_ras_cycles_out <= mwdt_pkg::RAS_WIDTH_BASE;
      column_bits_out <= mwdt_pkg::COL_BITS_BASE;
    end else begin
      precharge_cycles_out <= mem_ctrl_ff[mwdt_pkg::PRECHARGE_BIT] ? mwdt_pkg::TWO_CYCLES :
                              mwdt_pkg::ONE_CYCLE; // see R7
      row_col_cycles_out <= mem_ctrl_ff[mwdt_pkg::ROW_COL_BIT] ? mwdt_pkg::TWO_CYCLES :
                            mwdt_pkg::ONE_CYCLE; // see R7
      wr_precharge_cycles_out <= mem_ctrl_ff[mwdt_pkg::WR_PRECHARGE_BIT] ?
                                 mwdt_pkg::TWO_CYCLES : mwdt_pkg::ONE_CYCLE; // see R7
      refresh_ras_cycles_out <= (ras_code == 2'h3) ? 3'h4 :
                                mwdt_pkg::RAS_WIDTH_BASE + {1'b0, ras_code}; // see R8
      // Reserved column codes leave the previous width in force.
      if (!col_code[2]) begin
        column_bits_out <= mwdt_pkg::COL_BITS_BASE + {2'h0, col_code[1:0]}; // see R17
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      page_mode_out <= 1'b0;
      static_column_out <= 1'b0;
      sdram_burst_out <= 1'b0;
      a2_auto_precharge_out <= 1'b0;
      a3_auto_precharge_out <= 1'b0;
      refresh_enable_out <= 1'b0;
      self_refresh_out <= 1'b0;
      word_size_long_out <= 1'b0;
    end else begin
      page_mode_out <= burst_en & a3_dram; // see R9
      static_column_out <= burst_en & a3_psram; // see R10
      sdram_burst_out <= a2_sdram | a3_sdram; // see R11
      a2_auto_precharge_out <= a2_sdram; // see R14
      a3_auto_precharge_out <= a3_sdram & ~bank_open; // see R12, R13
      refresh_enable_out <= mem_ctrl_ff[mwdt_pkg::REFRESH_BIT]; // see R15
      self_refresh_out <= mem_ctrl_ff[mwdt_pkg::REFRESH_BIT] &
                          mem_ctrl_ff[mwdt_pkg::REFRESH_MODE_BIT]; // see R16
      word_size_long_out <= mem_ctrl_ff[mwdt_pkg::WORD_SIZE_BIT];
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign access_busy_out = busy_ff;
  assign access_done_out = done_ff;

  // Checks.
  idle_reset_val_a: assert property (@(posedge mclk_in) // see R1
    sys_rst_in |=> wait_ctrl_ff == mwdt_pkg::WAIT_CTRL_RST)
    else $error("Wait register not at reset value after reset.");

  long_wait_load_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // see R2
    (state_ff == mwdt_pkg::ST_IDLE && access_req_in && access_area_in == 2'h0 &&
     req_wait_code == mwdt_pkg::WAIT_LONG) |=> cnt_ff == 3'h3 + {1'b0, $past(long_wait_a0_in)})
    else $error("Long wait count not loaded for area 0.");

  ext_wait_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // see R3
    (state_ff == mwdt_pkg::ST_EXTW && ext_wait_in) |=> state_ff == mwdt_pkg::ST_EXTW && !done_ff)
    else $error("Access ended while external wait was requested.");

  cas_assert_len_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // see R4
    (area_type_in == mwdt_pkg::TYPE_A3_DRAM && wait_ctrl_ff[7:6] == 2'h1) |=>
    cas_assert_cycles_out == 2'h2)
    else $error("CAS assert length wrong for code 01.");

  psram_len_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // see R6
    (area_type_in == mwdt_pkg::TYPE_A3_PSRAM && wait_ctrl_ff[7:6] == 2'h0) |=>
    psram_cycles_out == 3'h2)
    else $error("Pseudo-SRAM cycle length wrong for code 00.");

  ras_width_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // see R8
    (mem_ctrl_ff[12:11] == 2'h1) |=> refresh_ras_cycles_out == 3'h3)
    else $error("Refresh row strobe width wrong for code 01.");

  area2_precharge_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // see R14
    (area_type_in == mwdt_pkg::TYPE_BOTH_SDRAM && bank_open) |=>
    a2_auto_precharge_out && !a3_auto_precharge_out)
    else $error("Bank-open mode applied to area 2.");

  gap_length_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // see R1
    (done_ff && cur_idle_code == 2'h2) |-> busy_ff ##1 busy_ff ##1 !busy_ff)
    else $error("Two idle cycles not inserted after access.");

endmodule : mwdt_ctrl

// >>> mwdt_mem_model.sv
// Behavioural external memory that stretches accesses through the wait input.
// Assumes the controller's busy level marks a running access on the same clock.
`timescale 1ns/100ps

module mwdt_mem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic busy_in,
  input wire logic [3:0] hold_in,
  output logic ext_wait_out
);
  logic [3:0] cnt_ff;

  // A slow part asks for waiting for hold_in cycles from the second busy cycle on; zero means prompt.
  always_ff @(posedge clk_in) begin
    if (rst_in || !busy_in) begin
      cnt_ff <= 4'h0;
      ext_wait_out <= 1'h0;
    end else begin
      ext_wait_out <= (cnt_ff < hold_in);
      if (cnt_ff != 4'hf) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
endmodule : mwdt_mem_model

// >>> test_memory_wait_and_dram_timing_config.sv
// Self-checking bench for the wait and DRAM timing block, APB master and access driver.
// Assumes mwdt_pkg, mwdt_ctrl and mwdt_mem_model are compiled before this file.
`timescale 1ns/100ps

module test_memory_wait_and_dram_timing_config;
  logic mclk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic psel_in = 1'h0;
  logic penable_in = 1'h0;
  logic pwrite_in = 1'h0;
  logic [31:0] paddr_in = 32'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, ext_wait;
  logic [2:0] area_type_in = 3'h0;
  logic [1:0] lw0 = 2'h0;
  logic [1:0] lw1 = 2'h0;
  logic [1:0] lw23 = 2'h0;
  logic req = 1'h0;
  logic [1:0] area = 2'h0;
  logic [3:0] hold = 4'h0;
  logic busy, done, page, stat, burst, a2ap, a3ap, refe, selfr, ws;
  logic [1:0] cas, a2cl, a3cl, pre, rc, wrp;
  logic [2:0] psr, ras;
  logic [3:0] col;
  int miscompares = 0;
  int cmp_count = 0;

  always #20 mclk_in = ~mclk_in;

  mwdt_ctrl u_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .area_type_in(area_type_in), .long_wait_a0_in(lw0),
    .long_wait_a1_in(lw1), .long_wait_a23_in(lw23), .access_req_in(req),
    .access_area_in(area), .ext_wait_in(ext_wait), .access_busy_out(busy),
    .access_done_out(done), .cas_assert_cycles_out(cas), .a2_cas_latency_out(a2cl),
    .a3_cas_latency_out(a3cl), .psram_cycles_out(psr), .precharge_cycles_out(pre),
    .row_col_cycles_out(rc), .wr_precharge_cycles_out(wrp), .refresh_ras_cycles_out(ras),
    .page_mode_out(page), .static_column_out(stat), .sdram_burst_out(burst),
    .a2_auto_precharge_out(a2ap), .a3_auto_precharge_out(a3ap),
    .refresh_enable_out(refe), .self_refresh_out(selfr), .word_size_long_out(ws),
    .column_bits_out(col));

  mwdt_mem_model u_mem (.clk_in(mclk_in), .rst_in(sys_rst_in), .busy_in(busy),
    .hold_in(hold), .ext_wait_out(ext_wait));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    k = 0;
    @(posedge mclk_in);
    psel_in <= 1'h1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge mclk_in);
    penable_in <= 1'h1;
    do begin
      @(posedge mclk_in);
      k++;
    end while (pready_out !== 1'h1 && k < 20);
    rd = prdata_out;
    err = pslverr_out;
    if (k >= 20) chk("pready", 32'h1, 32'h0);
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask : apb

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic err;
    apb(1'h0, a, 32'h0, d, err);
    chk(nm, e, d);
  endtask : rd_chk

  // Packs every decoded timing output in port order, expected from the fields.
  function automatic logic [29:0] dec_exp(input logic [2:0] t, input logic [15:0] m,
                                          input logic [15:0] w, input logic [3:0] c);
    logic a2s, a3s;
    a2s = (t == 3'h4) || (t == 3'h5);
    a3s = (t == 3'h1) || (t == 3'h5);
    return {(t == 3'h2) ? w[7:6] + 2'h1 : 2'h0, a2s ? w[5:4] + 2'h1 : 2'h0,
      a3s ? w[7:6] + 2'h1 : 2'h0, (t != 3'h3) ? 3'h0 : (w[7:6] == 2'h0) ? 3'h2 : 3'h4,
      m[15] ? 2'h2 : 2'h1, m[14] ? 2'h2 : 2'h1, m[13] ? 2'h2 : 2'h1,
      (m[12:11] == 2'h3) ? 3'h4 : 3'h2 + {1'h0, m[12:11]},
      m[10] && t == 3'h2, m[10] && t == 3'h3, a2s || a3s, a2s, a3s && !m[9],
      m[3], m[3] && m[2], m[6], c};
  endfunction : dec_exp

  function automatic logic [31:0] waits(input logic [1:0] c, input logic [1:0] lw);
    return (c == 2'h3) ? 32'h3 + lw : {30'h0, c};
  endfunction : waits

  // Issues one access and checks its length and the idle gap that follows.
  task automatic acc(input logic [1:0] a, input logic [31:0] en, input logic [1:0] idl);
    int n;
    int g;
    n = 0;
    g = 0;
    while (busy === 1'h1 && n < 30) begin
      @(posedge mclk_in);
      n++;
    end
    @(posedge mclk_in);
    req <= 1'h1;
    area <= a;
    @(posedge mclk_in);
    req <= 1'h0;
    n = 0;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
    end while (done !== 1'h1 && n < 40);
    if (en != 32'h0) chk("done_delay", en, n);
    else chk("ext_wait_delay", 32'h1, n > 5 && n <= 12);
    while (busy === 1'h1 && g < 10) begin
      @(posedge mclk_in);
      #1;
      g++;
    end
    chk("idle_gap", {30'h0, idl}, g);
  endtask : acc

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (30000) @(posedge mclk_in);
    miscompares++;
    report_and_stop();
  end

  initial begin
    logic [15:0] m, w;
    logic [2:0] t;
    logic [3:0] c;
    logic [31:0] d;
    logic err;
    void'($urandom(32'h6fb8));
    for (int r = 0; r < 2; r++) begin
      sys_rst_in <= 1'h1;
      repeat (5) @(posedge mclk_in);
      sys_rst_in <= 1'h0;
      area_type_in <= 3'h0;
      rd_chk("wait_reset", mwdt_pkg::WAIT_CTRL_ADDR, 32'h0000aaff);
      rd_chk("mem_reset", mwdt_pkg::MEM_CTRL_ADDR, 32'h0);
      chk("decode_reset", dec_exp(3'h0, 16'h0, 16'haaff, 4'h8), {2'h0, cas, a2cl, a3cl,
        psr, pre, rc, wrp, ras, page, stat, burst, a2ap, a3ap, refe, selfr, ws, col});
      apb(1'h1, 32'hffffffe4, 32'h0, d, err);
      chk("unmapped_err", 32'h1, err);
      apb(1'h0, 32'hffffffe0, 32'h0, d, err);
      chk("unmapped_data", 32'h0, d);
      c = 4'h8;
      for (int i = 0; i < 40; i++) begin
        t = 3'($urandom % 6);
        m = (i == 0) ? 16'hffff : 16'($urandom);
        w = 16'($urandom);
        w[7:6] = 2'($urandom % ((t == 3'h1 || t == 3'h5) ? 2 : 3));
        w[5:4] = 2'($urandom % 2);
        area_type_in <= t;
        apb(1'h1, mwdt_pkg::MEM_CTRL_ADDR, {16'($urandom), m}, d, err);
        apb(1'h1, mwdt_pkg::WAIT_CTRL_ADDR, {16'h0, w}, d, err);
        if ({m[7], m[5], m[4]} < 3'h4) c = 4'h8 + {1'h0, m[7], m[5], m[4]};
        rd_chk("mem_rw", mwdt_pkg::MEM_CTRL_ADDR, {16'h0, m & 16'hfefc});
        rd_chk("wait_rw", mwdt_pkg::WAIT_CTRL_ADDR, {16'h0, w});
        repeat (2) @(posedge mclk_in);
        chk("decode", dec_exp(t, m, w, c), {2'h0, cas, a2cl, a3cl, psr, pre, rc, wrp,
          ras, page, stat, burst, a2ap, a3ap, refe, selfr, ws, col});
      end
      $display("register test %0d done", r);
    end
    area_type_in <= 3'h0;
    for (int i = 0; i < 12; i++) begin
      w = 16'($urandom);
      for (int a = 0; a < 4; a++) w[9 + 2 * a -: 2] = 2'($urandom % 3);
      if (i == 0) w[7:0] = 8'hff;
      lw0 <= 2'($urandom);
      lw1 <= 2'($urandom);
      lw23 <= 2'($urandom);
      apb(1'h1, mwdt_pkg::WAIT_CTRL_ADDR, {16'h0, w}, d, err);
      for (int a = 0; a < 4; a++) begin
        acc(2'(a), 32'h1 + waits(w[2 * a +: 2], (a == 0) ? lw0 : (a == 1) ? lw1 : lw23),
          w[8 + 2 * a +: 2]);
      end
    end
    $display("sequencer test done");
    hold <= 4'h8;
    lw0 <= 2'h0;
    apb(1'h1, mwdt_pkg::WAIT_CTRL_ADDR, 32'h00000007, d, err);
    acc(2'h0, 32'h0, 2'h0);
    acc(2'h1, 32'h2, 2'h0);
    hold <= 4'h0;
    area_type_in <= 3'h2;
    apb(1'h1, mwdt_pkg::WAIT_CTRL_ADDR, 32'h000000c0, d, err);
    acc(2'h3, 32'h1, 2'h0);
    $display("external wait test done");
    report_and_stop();
  end
endmodule : test_memory_wait_and_dram_timing_config
